// ==== design/adc_cal_pkg.sv ====
// Purpose: shared constants and types for the calibration sequencer
// Assumes: master clock is clk; the _CYC counts below are in master clock periods
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone
package adc_cal_pkg;

	localparam int CAL_SELF_CYC    = 3145655;
	localparam int CAL_OFFS2_CYC   = 1052599;
	localparam int CAL_GAIN_CYC    = 1068813;
	localparam int CAL_OFFS1_CYC   = 2117389;
	localparam int STROBE_MIN_CYC  = 4;
	localparam int MOD_TICK_CYC    = 256;
	localparam int WIN_TICKS_DEF   = 64;
	localparam int SEG_UNI_16      = 65536;
	localparam int SEG_UNI_20      = 1048576;
	localparam int SEG_BIP_16      = 32768;
	localparam int SEG_BIP_20      = 524288;
	localparam int SLOPE_FRAC      = 8;
	localparam int DIV_STEPS       = 32;

	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_STATUS = 8'h04;
	localparam logic [7:0]  ADR_ZERO   = 8'h08;
	localparam logic [7:0]  ADR_FULL   = 8'h0C;
	localparam logic [7:0]  ADR_SLOPE  = 8'h10;
	localparam logic [7:0]  ADR_RESULT = 8'h14;
	localparam logic [31:0] CTRL_RESET = 32'h0;
	localparam int          CTRL_WIDE  = 0;
	localparam int          ST_STATE   = 0;
	localparam int          ST_MODE    = 3;
	localparam int          ST_CAL_OK  = 5;
	localparam int          ST_READY_N = 6;
	localparam int          ST_BIPOLAR = 7;
	localparam int          ST_DIVBUSY = 8;

	typedef enum logic [1:0] {
		MODE_SELF  = 2'b00,
		MODE_GAIN  = 2'b01,
		MODE_OFFS1 = 2'b10,
		MODE_OFFS2 = 2'b11
	} calMode_t;

	typedef enum logic [1:0] {
		SRC_AIN = 2'b00,
		SRC_GND = 2'b01,
		SRC_REF = 2'b10
	} source_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HOLD = 2'b01,
		ST_CAL  = 2'b10,
		ST_CONV = 2'b11
	} seqState_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wbReq_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wbRsp_t;

	typedef struct packed {
		logic calStrobe;
		logic selBitA;
		logic selBitB;
		logic polaritySelect;
		logic modBit;
	} pins_t;

endpackage

// ==== design/adc_calibration_sequencer.sv ====
// Purpose: calibration sequencer, slope arithmetic and conversion scaling
// Assumes: pins are asynchronous; bus and sequencer share clk
// Notes: registers over classic Wishbone, one wait cycle per access
`timescale 1ns/1ps
module adc_calibration_sequencer #(
	parameter int SELF_CYC  = adc_cal_pkg::CAL_SELF_CYC,
	parameter int OFFS2_CYC = adc_cal_pkg::CAL_OFFS2_CYC,
	parameter int GAIN_CYC  = adc_cal_pkg::CAL_GAIN_CYC,
	parameter int OFFS1_CYC = adc_cal_pkg::CAL_OFFS1_CYC,
	parameter int WIN_TICKS = adc_cal_pkg::WIN_TICKS_DEF
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire adc_cal_pkg::wbReq_t wbReq,
	output adc_cal_pkg::wbRsp_t      wbRsp,
	input  wire adc_cal_pkg::pins_t  pinsIn,
	output logic                     result_valid_n,
	output logic [19:0]              resultWord,
	output adc_cal_pkg::source_t     inputSource
);
	import adc_cal_pkg::*;

	localparam int NPIN    = 5;
	localparam int MIN_SYS = (OFFS2_CYC < GAIN_CYC) ? OFFS2_CYC : GAIN_CYC;
	localparam int MIN_ONE = (SELF_CYC < OFFS1_CYC) ? SELF_CYC : OFFS1_CYC;
	localparam int MIN_CAL = (MIN_SYS < MIN_ONE) ? MIN_SYS : MIN_ONE;
	localparam int MAX_CNT = 4194304;

	// every step must hold both windows plus the divide, and fit the 22-bit step counter
	if (WIN_TICKS < 2 || WIN_TICKS > 65535 ||
		2 * WIN_TICKS * MOD_TICK_CYC + DIV_STEPS + 2 >= MIN_CAL ||
		SELF_CYC >= MAX_CNT || OFFS1_CYC >= MAX_CNT ||
		OFFS2_CYC >= MAX_CNT || GAIN_CYC >= MAX_CNT) begin : bad_param
		$error("calibration windows do not fit the step lengths");
	end

	// three-stage synchronisers, a change is taken once stages two and three agree
	logic [NPIN-1:0] syncA_reg;
	logic [NPIN-1:0] syncB_reg;
	logic [NPIN-1:0] syncC_reg;
	logic [NPIN-1:0] pinVal_reg;
	logic [NPIN-1:0] pinVal_next;
	pins_t           pin;

	for (genvar i = 0; i < NPIN; i++) begin : g_sync
		always_comb begin
			pinVal_next[i] = (syncB_reg[i] == syncC_reg[i]) ? syncC_reg[i] : pinVal_reg[i];
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				syncA_reg[i]  <= 1'b0;
				syncB_reg[i]  <= 1'b0;
				syncC_reg[i]  <= 1'b0;
				pinVal_reg[i] <= 1'b0;
			end else begin
				syncA_reg[i]  <= pinsIn[i];
				syncB_reg[i]  <= syncA_reg[i];
				syncC_reg[i]  <= syncB_reg[i];
				pinVal_reg[i] <= pinVal_next[i];
			end
		end
	end
	assign pin = pins_t'(pinVal_reg);

	seqState_t   state_reg, state_next;
	calMode_t    mode_reg, mode_next;
	source_t     source_reg, source_next;
	logic [21:0] calCnt_reg, calCnt_next;
	logic [2:0]  strobeCnt_reg, strobeCnt_next;
	logic [7:0]  tickCnt_reg, tickCnt_next;
	logic [15:0] winCnt_reg, winCnt_next;
	logic [15:0] acc_reg, acc_next;
	logic [1:0]  phase_reg, phase_next;
	logic [15:0] zero_reg, zero_next;
	logic [15:0] full_reg, full_next;
	logic [31:0] slope_reg, slope_next;
	logic [31:0] divQ_reg, divQ_next;
	logic [31:0] divR_reg, divR_next;
	logic [5:0]  divCnt_reg, divCnt_next;
	logic        divBusy_reg, divBusy_next;
	logic        calOk_reg, calOk_next;
	logic [19:0] result_reg, result_next;
	logic        readyN_reg, readyN_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic        ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;

	logic               tick;
	logic               winEnd;
	logic [21:0]        calLen;
	logic               wide;
	logic [19:0]        maxCode;
	logic [31:0]        segments;
	logic [15:0]        span;
	logic [31:0]        remShift;
	logic signed [16:0] diff;
	logic signed [49:0] prod;
	logic signed [49:0] scaled;
	logic [19:0]        code;
	logic               wbHit;

	assign wide    = ctrl_reg[CTRL_WIDE];
	assign maxCode = wide ? 20'hFFFFF : 20'h0FFFF;
	assign tick    = (tickCnt_reg == 8'(MOD_TICK_CYC - 1));
	assign winEnd  = tick && (winCnt_reg == 16'(WIN_TICKS - 1));
	assign span    = full_reg - zero_reg;
	assign remShift = {divR_reg[30:0], divQ_reg[31]};
	assign wbHit   = wbReq.cyc && wbReq.stb && !ack_reg;

	// step length per latched mode
	always_comb begin
		unique case (mode_reg)
			MODE_SELF:  calLen = 22'(SELF_CYC);
			MODE_OFFS2: calLen = 22'(OFFS2_CYC);
			MODE_GAIN:  calLen = 22'(GAIN_CYC);
			MODE_OFFS1: calLen = 22'(OFFS1_CYC);
		endcase
	end

	// segment count: bipolar uses half, the other half lies below zero scale
	always_comb begin
		if (pin.polaritySelect) begin
			segments = wide ? 32'(SEG_BIP_20) : 32'(SEG_BIP_16);
		end else begin
			segments = wide ? 32'(SEG_UNI_20) : 32'(SEG_UNI_16);
		end
	end

	// output code from the stored slope; out-of-range saturates to the rails
	always_comb begin
		// the window's last tick is still on its way into acc_reg when the window ends
		diff   = $signed({1'b0, acc_reg + {15'h0, pin.modBit}}) - $signed({1'b0, zero_reg});
		prod   = diff * $signed({1'b0, slope_reg});
		scaled = prod >>> SLOPE_FRAC;
		if (pin.polaritySelect) begin
			scaled = scaled + (wide ? 50'sh80000 : 50'sh8000);
		end
		if (scaled < 0) begin
			code = 20'h0;
		end else if (scaled > $signed({30'h0, maxCode})) begin
			code = maxCode;
		end else begin
			code = scaled[19:0];
		end
	end

	always_comb begin
		state_next     = state_reg;
		mode_next      = mode_reg;
		source_next    = source_reg;
		calCnt_next    = calCnt_reg;
		strobeCnt_next = strobeCnt_reg;
		tickCnt_next   = tickCnt_reg + 8'h1;
		winCnt_next    = winCnt_reg;
		acc_next       = acc_reg;
		phase_next     = phase_reg;
		zero_next      = zero_reg;
		full_next      = full_reg;
		slope_next     = slope_reg;
		divQ_next      = divQ_reg;
		divR_next      = divR_reg;
		divCnt_next    = divCnt_reg;
		divBusy_next   = divBusy_reg;
		calOk_next     = calOk_reg;
		result_next    = result_reg;
		readyN_next    = readyN_reg;

		// modulator bit is only looked at once per tick, so faster edges are ignored
		if (tick && (state_reg == ST_CAL || state_reg == ST_CONV)) begin
			acc_next    = acc_reg + {15'h0, pin.modBit};
			winCnt_next = winCnt_reg + 16'h1;
		end

		unique case (state_reg)
			ST_IDLE: begin
				source_next = SRC_AIN;
			end
			ST_HOLD: begin
				// everything held off while the strobe stays high
				tickCnt_next = 8'h0;
				divBusy_next = 1'b0;
				readyN_next  = 1'b1;
				if (strobeCnt_reg != 3'(STROBE_MIN_CYC)) begin
					strobeCnt_next = strobeCnt_reg + 3'h1;
				end
				if (!pin.calStrobe) begin
					if (strobeCnt_reg == 3'(STROBE_MIN_CYC)) begin
						mode_next   = calMode_t'({pin.selBitA, pin.selBitB});
						state_next  = ST_CAL;
						calCnt_next = 22'h0;
						winCnt_next = 16'h0;
						acc_next    = 16'h0;
						phase_next  = 2'h0;
						source_next = ({pin.selBitA, pin.selBitB} == MODE_SELF) ? SRC_GND : SRC_AIN;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_CAL: begin
				readyN_next = 1'b1;
				calCnt_next = calCnt_reg + 22'h1;
				if (winEnd && phase_reg != 2'h2) begin
					winCnt_next = 16'h0;
					phase_next  = phase_reg + 2'h1;
					if (phase_reg == 2'h0) begin
						if (mode_reg != MODE_GAIN) begin
							zero_next = acc_next;
						end
						source_next = (mode_reg == MODE_SELF || mode_reg == MODE_OFFS1) ?
							SRC_REF : SRC_AIN;
					end else begin
						source_next = SRC_AIN;
						// an offset-only step leaves the slope alone
						if (mode_reg != MODE_OFFS2) begin
							full_next    = acc_next;
							divBusy_next = 1'b1;
							divCnt_next  = 6'h0;
							divR_next    = 32'h0;
							divQ_next    = segments << SLOPE_FRAC;
						end
					end
					// cleared only after capture, so the last tick of the window counts
					acc_next = 16'h0;
				end
				if (phase_reg == 2'h2) begin
					winCnt_next = 16'h0;
					acc_next    = 16'h0;
				end
				// restoring divide, one quotient bit per clock
				if (divBusy_reg) begin
					divCnt_next = divCnt_reg + 6'h1;
					if (remShift >= {16'h0, span}) begin
						divR_next = remShift - {16'h0, span};
						divQ_next = {divQ_reg[30:0], 1'b1};
					end else begin
						divR_next = remShift;
						divQ_next = {divQ_reg[30:0], 1'b0};
					end
					if (divCnt_reg == 6'(DIV_STEPS - 1)) begin
						divBusy_next = 1'b0;
						// a zero or inverted span cannot be scaled: clamp the slope
						slope_next   = (full_reg > zero_reg) ? divQ_next : 32'hFFFFFFFF;
						calOk_next   = 1'b1;
					end
				end
				if (calCnt_reg == calLen - 22'h1) begin
					state_next   = ST_CONV;
					tickCnt_next = 8'h0;
					winCnt_next  = 16'h0;
					acc_next     = 16'h0;
					source_next  = SRC_AIN;
					unique case (mode_reg)
						MODE_SELF: begin
							readyN_next = 1'b1;
						end
						MODE_GAIN: begin
							result_next = maxCode;
							readyN_next = 1'b0;
						end
						MODE_OFFS1, MODE_OFFS2: begin
							result_next = 20'h0;
							readyN_next = 1'b0;
						end
					endcase
				end
			end
			ST_CONV: begin
				if (winEnd) begin
					acc_next    = 16'h0;
					winCnt_next = 16'h0;
					// first window after self cal is the settling point
					result_next = code;
					readyN_next = 1'b0;
				end
			end
		endcase

		if (pin.calStrobe) begin
			state_next     = ST_HOLD;
			source_next    = SRC_AIN;
			readyN_next    = 1'b1;
			divBusy_next   = 1'b0;
			if (state_reg != ST_HOLD) begin
				strobeCnt_next = 3'h1;
			end
		end
	end

	// bus slave: every access answered one cycle later, unmapped reads are zero
	always_comb begin
		ctrl_next = ctrl_reg;
		ack_next  = wbHit;
		rdat_next = rdat_reg;
		if (wbHit) begin
			rdat_next = 32'h0;
			if (wbReq.we) begin
				if (wbReq.adr == ADR_CTRL && wbReq.sel[0]) begin
					ctrl_next = {31'h0, wbReq.dat[CTRL_WIDE]};
				end
			end else begin
				unique case (wbReq.adr)
					ADR_CTRL:   rdat_next = ctrl_reg;
					ADR_STATUS: begin
						rdat_next[ST_STATE +: 2] = state_reg;
						rdat_next[ST_MODE +: 2]  = mode_reg;
						rdat_next[ST_CAL_OK]     = calOk_reg;
						rdat_next[ST_READY_N]    = readyN_reg;
						rdat_next[ST_BIPOLAR]    = pin.polaritySelect;
						rdat_next[ST_DIVBUSY]    = divBusy_reg;
					end
					ADR_ZERO:   rdat_next = {16'h0, zero_reg};
					ADR_FULL:   rdat_next = {16'h0, full_reg};
					ADR_SLOPE:  rdat_next = slope_reg;
					ADR_RESULT: rdat_next = {12'h0, result_reg};
					default:    rdat_next = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg     <= ST_IDLE;
			mode_reg      <= MODE_SELF;
			source_reg    <= SRC_AIN;
			calCnt_reg    <= 22'h0;
			strobeCnt_reg <= 3'h0;
			tickCnt_reg   <= 8'h0;
			winCnt_reg    <= 16'h0;
			acc_reg       <= 16'h0;
			phase_reg     <= 2'h0;
			zero_reg      <= 16'h0;
			full_reg      <= 16'h0;
			slope_reg     <= 32'h0;
			divQ_reg      <= 32'h0;
			divR_reg      <= 32'h0;
			divCnt_reg    <= 6'h0;
			divBusy_reg   <= 1'b0;
			calOk_reg     <= 1'b0;
			result_reg    <= 20'h0;
			readyN_reg    <= 1'b1;
			ctrl_reg      <= CTRL_RESET;
			ack_reg       <= 1'b0;
			rdat_reg      <= 32'h0;
		end else begin
			state_reg     <= state_next;
			mode_reg      <= mode_next;
			source_reg    <= source_next;
			calCnt_reg    <= calCnt_next;
			strobeCnt_reg <= strobeCnt_next;
			tickCnt_reg   <= tickCnt_next;
			winCnt_reg    <= winCnt_next;
			acc_reg       <= acc_next;
			phase_reg     <= phase_next;
			zero_reg      <= zero_next;
			full_reg      <= full_next;
			slope_reg     <= slope_next;
			divQ_reg      <= divQ_next;
			divR_reg      <= divR_next;
			divCnt_reg    <= divCnt_next;
			divBusy_reg   <= divBusy_next;
			calOk_reg     <= calOk_next;
			result_reg    <= result_next;
			readyN_reg    <= readyN_next;
			ctrl_reg      <= ctrl_next;
			ack_reg       <= ack_next;
			rdat_reg      <= rdat_next;
		end
	end

	assign wbRsp.ack      = ack_reg;
	assign wbRsp.dat      = rdat_reg;
	assign result_valid_n = readyN_reg;
	assign resultWord     = result_reg;
	assign inputSource    = source_reg;

endmodule // adc_calibration_sequencer

// ==== verif/adc_cal_props.sv ====
// Purpose: port checks for the calibration sequencer
// Assumes: host holds selects steady while the strobe is high
// Notes: step time is measured from strobe release, so sync delay needs slack
`timescale 1ns/1ps
module adc_cal_props
	import adc_cal_pkg::*;
#(
	parameter int SELF_CYC  = CAL_SELF_CYC,
	parameter int OFFS2_CYC = CAL_OFFS2_CYC,
	parameter int GAIN_CYC  = CAL_GAIN_CYC,
	parameter int OFFS1_CYC = CAL_OFFS1_CYC,
	parameter int WIN_TICKS = WIN_TICKS_DEF
) (
	input wire logic                clk,
	input wire logic                sys_rst,
	input wire adc_cal_pkg::wbReq_t wbReq,
	input wire adc_cal_pkg::wbRsp_t wbRsp,
	input wire adc_cal_pkg::pins_t  pinsIn,
	input wire logic                result_valid_n,
	input wire logic [19:0]         resultWord,
	input wire adc_cal_pkg::source_t inputSource
);
	localparam int SLACK = 48;
	logic [1:0] modeReg;
	logic       armed;
	int         runCnt;
	int         expCnt;

	// runCnt restarts while the strobe is high, so an abort never looks late
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			modeReg <= 2'h0;
			armed   <= 1'b0;
			runCnt  <= 0;
		end else begin
			if ($fell(pinsIn.calStrobe)) begin
				modeReg <= {pinsIn.selBitA, pinsIn.selBitB};
			end
			armed  <= $fell(pinsIn.calStrobe) | (armed & result_valid_n);
			runCnt <= pinsIn.calStrobe ? 0 : runCnt + 1;
		end
	end

	always_comb begin
		case (modeReg)
			2'b00:   expCnt = SELF_CYC + WIN_TICKS * MOD_TICK_CYC;
			2'b11:   expCnt = OFFS2_CYC;
			2'b01:   expCnt = GAIN_CYC;
			default: expCnt = OFFS1_CYC;
		endcase
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_strobe_busy: assert property (pinsIn.calStrobe [*6] |-> result_valid_n)
		else $error("ready low while strobe held");
	a_ready_holds: assert property (!result_valid_n && !pinsIn.calStrobe |=> !result_valid_n)
		else $error("ready rose without strobe");
	a_step_time: assert property ($fell(result_valid_n) |->
		runCnt >= expCnt && runCnt <= expCnt + SLACK)
		else $error("step length wrong for mode");
	a_busy_bound: assert property (armed |-> runCnt <= SELF_CYC + WIN_TICKS * MOD_TICK_CYC + SLACK)
		else $error("step never ended");
	a_gain_code: assert property ($fell(result_valid_n) && modeReg == 2'b01 |->
		resultWord[15:0] == 16'hFFFF)
		else $error("gain step code not full scale");
	a_offs_code: assert property ($fell(result_valid_n) && modeReg[1] |->
		resultWord == 20'h00000)
		else $error("offset step code not zero");
	a_self_ground: assert property (armed && modeReg == 2'b00 && runCnt == 64 |->
		inputSource == SRC_GND)
		else $error("self cal zero not from ground");
	a_sys_input: assert property (armed && modeReg[1] && runCnt == 64 |->
		inputSource == SRC_AIN)
		else $error("system offset not from input");
	a_ack_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
		else $error("ack longer than one cycle");
	a_ack_prompt: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
		else $error("ack late");
endmodule // adc_cal_props

bind adc_calibration_sequencer adc_cal_props #(
	.SELF_CYC(SELF_CYC), .OFFS2_CYC(OFFS2_CYC), .GAIN_CYC(GAIN_CYC),
	.OFFS1_CYC(OFFS1_CYC), .WIN_TICKS(WIN_TICKS)
) adc_cal_props_inst (
	.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .pinsIn(pinsIn),
	.result_valid_n(result_valid_n), .resultWord(resultWord), .inputSource(inputSource)
);

// ==== verif/adc_cal_host.sv ====
// Purpose: host model driving strobe, selects, polarity and modulator bit
// Assumes: tasks are called right after a rising clock edge
// Notes: modulator level is a flat 0 or 1, which is enough for code checks
`timescale 1ns/1ps
module adc_cal_host
	import adc_cal_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic level,
	input  wire logic bipolar,
	output pins_t     pinsOut
);
	logic       strobe = 1'b0;
	logic       selA   = 1'b0;
	logic       selB   = 1'b0;
	logic [7:0] tickCnt;
	logic       modReg;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tickCnt <= 8'h00;
			modReg  <= 1'b0;
		end else begin
			tickCnt <= tickCnt + 8'h01;
			if (tickCnt == 8'hFF) begin
				modReg <= level;
			end
		end
	end

	// polarity comes straight from the bench, which changes it only before a recal
	assign pinsOut = '{calStrobe: strobe, selBitA: selA, selBitB: selB,
		polaritySelect: bipolar, modBit: modReg};

	task automatic raiseStrobe(input logic [1:0] mode);
		strobe <= 1'b1;
		selA   <= mode[1];
		selB   <= mode[0];
	endtask

	task automatic dropStrobe();
		strobe <= 1'b0;
	endtask
endmodule // adc_cal_host

// ==== verif/adc_calibration_sequencer_test.sv ====
// Purpose: register and calibration step tests of the sequencer
// Assumes: short step counts set through parameters
// Notes: calibration input level is only changed between steps
`timescale 1ns/1ps
module adc_calibration_sequencer_test;
	import adc_cal_pkg::*;
	localparam int SELF = 2000;
	localparam int OFF2 = 2100;
	localparam int GAIN = 2200;
	localparam int OFF1 = 2300;
	localparam int WIN  = 2;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	wbReq_t      wbReq = '0;
	wbRsp_t      wbRsp;
	pins_t       pins;
	logic        result_valid_n;
	logic [19:0] resultWord;
	source_t     inputSource;
	logic        level = 1'b0;
	logic        bip = 1'b0;
	int          n_fail = 0;
	int          n_compared = 0;
	logic [31:0] q;
	logic [31:0] s1;

	always #12.5 clk = ~clk;

	adc_calibration_sequencer #(.SELF_CYC(SELF), .OFFS2_CYC(OFF2), .GAIN_CYC(GAIN),
		.OFFS1_CYC(OFF1), .WIN_TICKS(WIN)) adc_calibration_sequencer_inst (
		.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .pinsIn(pins),
		.result_valid_n(result_valid_n), .resultWord(resultWord),
		.inputSource(inputSource));

	adc_cal_host adc_cal_host_inst (.clk(clk), .sys_rst(sys_rst), .level(level),
		.bipolar(bip), .pinsOut(pins));

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int i;
		i = 0;
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
		do begin
			@(posedge clk);
			i++;
		end while (wbRsp.ack !== 1'b1 && i < 20);
		rd = wbRsp.dat;
		wbReq <= '0;
		if (wbRsp.ack !== 1'b1) begin
			n_fail++;
			summarize();
		end
		@(posedge clk);
	endtask

	// probe reads status while the strobe is still held
	task automatic runCal(input logic [1:0] mode, input int e, input logic probe);
		int n;
		n = 0;
		adc_cal_host_inst.raiseStrobe(mode);
		repeat (6) @(posedge clk);
		if (probe) begin
			wbXfer(1'b0, ADR_STATUS, 32'h0, q);
			check(q & 32'h83, 32'h81);
			check({31'h0, result_valid_n}, 32'h1);
		end
		adc_cal_host_inst.dropStrobe();
		while (result_valid_n !== 1'b0 && n < 6000) begin
			@(posedge clk);
			n++;
			if (n == 64 && mode != 2'b01) begin
				check(inputSource, (mode == 2'b00) ? SRC_GND : SRC_AIN);
			end
			// with two-tick windows, 700 clocks in lies inside the full-scale window
			if (n == 700) begin
				check(inputSource, mode[0] ? SRC_AIN : SRC_REF);
			end
		end
		if (n >= 6000) begin
			n_fail++;
			summarize();
		end
		check({31'h0, n >= e && n <= e + 48}, 32'h1);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check({31'h0, result_valid_n}, 32'h1);
		check({12'h0, resultWord}, 32'h0);
		wbXfer(1'b0, ADR_CTRL, 32'h0, q);
		check(q, CTRL_RESET);
		wbXfer(1'b1, ADR_STATUS, 32'hFF, q);
		wbXfer(1'b0, ADR_STATUS, 32'h0, q);
		check(q & 32'h63, 32'h40);
		wbXfer(1'b0, 8'h18, 32'h0, q);
		check(q, 32'h0);
		level <= 1'b1;
		runCal(2'b00, SELF + WIN * 256, 1'b0);
		wbXfer(1'b0, ADR_STATUS, 32'h0, q);
		check(q & 32'h38, 32'h20);
		level <= 1'b0;
		runCal(2'b11, OFF2, 1'b0);
		check({12'h0, resultWord}, 32'h0);
		level <= 1'b1;
		runCal(2'b01, GAIN, 1'b0);
		check({12'h0, resultWord}, 32'h0FFFF);
		wbXfer(1'b0, ADR_SLOPE, 32'h0, s1);
		// flat input: the zero kept from the offset step counted no ones, the full window one per tick
		check(s1, (32'(SEG_UNI_16) << SLOPE_FRAC) / WIN);
		wbXfer(1'b0, ADR_ZERO, 32'h0, q);
		check(q, 32'h0);
		wbXfer(1'b0, ADR_FULL, 32'h0, q);
		check(q, WIN);
		wbXfer(1'b0, ADR_RESULT, 32'h0, q);
		check(q, 32'h0FFFF);
		level <= 1'b0;
		runCal(2'b11, OFF2, 1'b0);
		wbXfer(1'b0, ADR_SLOPE, 32'h0, q);
		check(q, s1);
		wbXfer(1'b1, ADR_CTRL, 32'h1, q);
		wbXfer(1'b0, ADR_CTRL, 32'h0, q);
		check(q, 32'h1);
		level <= 1'b1;
		runCal(2'b01, GAIN, 1'b0);
		check({12'h0, resultWord}, 32'hFFFFF);
		level <= 1'b0;
		runCal(2'b10, OFF1, 1'b0);
		check({12'h0, resultWord}, 32'h0);
		// a self cal cut short by a new strobe, polarity changed before it
		bip <= 1'b1;
		adc_cal_host_inst.raiseStrobe(2'b00);
		repeat (6) @(posedge clk);
		adc_cal_host_inst.dropStrobe();
		repeat (300) @(posedge clk);
		runCal(2'b11, OFF2, 1'b1);
		// one conversion window later a zero-scale input sits at mid code in bipolar
		repeat (WIN * MOD_TICK_CYC + 88) @(posedge clk);
		check({12'h0, resultWord}, 32'(SEG_BIP_20));
		summarize();
	end
endmodule // adc_calibration_sequencer_test
